//--- rtl/eid_pkg.sv
// Package of constants, opcodes, states and carrier types for the extended decoder.
package eid_pkg;

   localparam int          EID_AW   = 12;
   localparam int          EID_PCW  = 21;
   localparam int          EID_FP   = 2;
   // Register indices on the plain register port.
   localparam logic [3:0]  REG_CTRL = 4'h0;
   localparam logic [3:0]  REG_FP   = 4'h1;
   localparam logic [3:0]  REG_PTR0 = 4'h2;
   localparam logic [3:0]  REG_PTR1 = 4'h3;
   localparam logic [3:0]  REG_WORK = 4'h4;
   localparam logic [3:0]  REG_LATH = 4'h5;
   localparam logic [3:0]  REG_LATU = 4'h6;
   localparam logic [3:0]  REG_BANK = 4'h7;
   localparam logic [3:0]  REG_STAT = 4'h8;
   localparam int          CTRL_EXT_BIT = 0;
   // Opcode fields.
   localparam logic [15:0] OPC_CALL_W = 16'h0014;
   localparam logic [7:0]  OPC_MOVS   = 8'heb;
   localparam logic [7:0]  OPC_PUSH_K = 8'hea;
   localparam logic [7:0]  OPC_SUB_P  = 8'he9;
   localparam logic [1:0]  SEL_RETURN = 2'h3;
   // Indirect register windows: each top address and the four below it.
   localparam logic [2:0][11:0] IND_TOP  = {12'hfdf, 12'hfe7, 12'hfef};
   localparam logic [11:0] IND_SPAN   = 12'h004;
   // Access bank split and upper page of the special registers.
   localparam logic [7:0]  ACC_LIMIT  = 8'h5f;
   localparam logic [3:0]  ACC_PAGE   = 4'hf;
   localparam logic [20:0] PC_STEP    = 21'h000002;
   // Instruction phases within one instruction cycle.
   localparam logic [1:0]  Q1 = 2'h0;
   localparam logic [1:0]  Q2 = 2'h1;
   localparam logic [1:0]  Q3 = 2'h2;
   localparam logic [1:0]  Q4 = 2'h3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_FIRST = 2'b01, ST_SECOND = 2'b11, ST_NOP = 2'b10
   } eid_state_t;

   typedef enum logic [2:0] {
      OP_NONE, OP_MOVE_F, OP_MOVE_X, OP_PUSH_K, OP_SUB_P, OP_SUB_RET, OP_CALL_W
   } eid_op_t;

   typedef struct packed {
      logic        re;
      logic        we;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } eid_mem_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic        dest_f;
   } eid_xlate_t;

   typedef struct packed {
      eid_state_t      state;
      logic [1:0]      phase;
      eid_op_t         op;
      logic [15:0]     word1;
      logic [15:0]     word2;
      logic            ext_en;
      logic [2:0][11:0] ptr;
      logic [7:0]      work;
      logic [7:0]      lath;
      logic [7:0]      latu;
      logic [7:0]      bank;
      logic [7:0]      src;
      logic [20:0]     ret;
      eid_mem_t        mem;
      logic            push;
      logic            pc_load;
      logic [20:0]     pc_val;
      logic [15:0]     rd;
      eid_xlate_t      xl;
      logic            busy;
   } eid_regs_t;

   localparam eid_regs_t REGS_RST = '0;

endpackage : eid_pkg

//--- rtl/eid_core.sv
// Decode and execute unit for the extended instructions and indexed offset addressing.
//
// Overview of operation
// [RULE_01] Move-to-file source is frame pointer plus 7-bit offset, anywhere in 4096 bytes.
// [RULE_02] Move-to-file destination is the 12-bit literal of the second word.
// [RULE_03] Software never targets pc low byte or return-top bytes with indexed moves.
// [RULE_04] A source landing on an indirect register reads as 00h.
// [RULE_05] Move-indexed-to-indexed with indirect destination writes nothing.
// [RULE_06] Indexed-to-indexed uses two words; both addresses are pointer plus offset.
// [RULE_07] Indexed moves take two cycles; read in first, write in second Q4.
// [RULE_08] Push literal writes at frame pointer then decrements it, one cycle.
// [RULE_09] Subtract literal from pointer 0 to 2 in one cycle, flags untouched.
// [RULE_10] Select value 3 subtracts from frame pointer, returns, then idles a cycle.
// [RULE_11] Call via working register takes two cycles, second one idle.
// [RULE_12] Enabling the extension also enables indexed offset operand translation.
// [RULE_13] Disabled: operand is access bank when a is 0, bank register otherwise.
// [RULE_14] Enabled with a 0: operands up to 5Fh are frame pointer offsets.
// [RULE_15] A zero frame pointer maps offsets onto the normal access bank.
// [RULE_16] The destination bit keeps its normal meaning in indexed mode.
// [RULE_17] Software encodes indexed operands with a 0 and offset at most 5Fh.
// [RULE_18] Call pushes next address, loads pc from working register and latches.
// [RULE_19] Extension is active only with its enable bit set; reset clears it. The call form decodes even with the bit clear.
// [RULE_20] Indexed addresses are the low 12 bits of pointer plus unsigned offset.
module eid_core
   import eid_pkg::*;
#(
   parameter int unsigned DATA_SPACE = 4096
) (
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   input  wire logic [3:0]   reg_addr_in,
   input  wire logic [15:0]  reg_wdata_in,
   input  wire logic         reg_wr_in,
   input  wire logic         reg_rd_in,
   output logic      [15:0]  reg_rdata_out,
   input  wire logic         instr_valid_in,
   input  wire logic [15:0]  instr_word_in,
   input  wire logic [20:0]  pc_in,
   input  wire logic [20:0]  top_in,
   output eid_mem_t          mem_req_out,
   input  wire logic [7:0]   mem_rdata_in,
   output logic              stack_push_out,
   output logic      [20:0]  push_value_out,
   output logic              pc_load_out,
   output logic      [20:0]  pc_value_out,
   output logic              busy_out,
   output logic      [1:0]   phase_out,
   input  wire logic         std_valid_in,
   input  wire logic [7:0]   std_f_in,
   input  wire logic         std_a_in,
   input  wire logic         std_d_in,
   output eid_xlate_t        std_xlate_out
);

   if (DATA_SPACE != (1 << EID_AW)) begin : g_bad_space
      $error("Data space must match the 12-bit address width.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Decode a first word; only the call form is open while the extension is off.
   function automatic eid_op_t decode(input logic [15:0] w, input logic x);
      decode = OP_NONE;
      if (w == OPC_CALL_W) begin
         decode = OP_CALL_W;
      end else if (x) begin // [RULE_19]
         case (w[15:8])
            OPC_MOVS:   decode = w[7] ? OP_MOVE_X : OP_MOVE_F; // [RULE_06]
            OPC_PUSH_K: decode = OP_PUSH_K;
            OPC_SUB_P:  decode = (w[7:6] == SEL_RETURN) ? OP_SUB_RET : OP_SUB_P; // [RULE_10]
            default:    decode = OP_NONE;
         endcase
      end
   endfunction : decode

   // Tell whether an address falls on one of the indirect addressing registers.
   function automatic logic is_ind(input logic [11:0] a);
      is_ind = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (a <= IND_TOP[i] && a >= IND_TOP[i] - IND_SPAN) begin
            is_ind = 1'b1;
         end
      end
   endfunction : is_ind

   ////////////////////////////////////////////////////////////////////////////
   // State and datapath.

   eid_regs_t s;
   eid_regs_t next_s;
   logic [11:0] fp;
   logic [11:0] src_addr;
   logic [11:0] dst_addr;
   logic        movs;

   // Indexed addresses keep the low 12 bits of the sum.
   assign fp       = s.ptr[EID_FP];
   assign src_addr = fp + {5'h00, s.word1[6:0]}; // [RULE_01] [RULE_20]
   assign dst_addr = (s.op == OP_MOVE_F) ? s.word2[11:0]              // [RULE_02]
                                         : fp + {5'h00, s.word2[6:0]}; // [RULE_06]
   assign movs     = (s.op == OP_MOVE_F) || (s.op == OP_MOVE_X);

   // Next-state logic for registers, instruction sequencing and translation.
   always_comb begin
      next_s         = s;
      next_s.phase   = s.phase + 2'h1;
      next_s.mem     = '0;
      next_s.push    = 1'b0;
      next_s.pc_load = 1'b0;
      next_s.rd      = '0;
      next_s.xl      = '0;

      // Software writes land first; an instruction in the same cycle wins.
      if (reg_wr_in) begin
         case (reg_addr_in)
            REG_CTRL: next_s.ext_en = reg_wdata_in[CTRL_EXT_BIT];
            REG_FP:   next_s.ptr[2] = reg_wdata_in[11:0];
            REG_PTR0: next_s.ptr[0] = reg_wdata_in[11:0];
            REG_PTR1: next_s.ptr[1] = reg_wdata_in[11:0];
            REG_WORK: next_s.work   = reg_wdata_in[7:0];
            REG_LATH: next_s.lath   = reg_wdata_in[7:0];
            REG_LATU: next_s.latu   = reg_wdata_in[7:0];
            REG_BANK: next_s.bank   = reg_wdata_in[7:0];
            default:  next_s.ext_en = s.ext_en;
         endcase
      end

      // Read data stands in the cycle after the strobe; unmapped reads give zero.
      if (reg_rd_in) begin
         case (reg_addr_in)
            REG_CTRL: next_s.rd = {15'h0000, s.ext_en};
            REG_FP:   next_s.rd = {4'h0, s.ptr[2]};
            REG_PTR0: next_s.rd = {4'h0, s.ptr[0]};
            REG_PTR1: next_s.rd = {4'h0, s.ptr[1]};
            REG_WORK: next_s.rd = {8'h00, s.work};
            REG_LATH: next_s.rd = {8'h00, s.lath};
            REG_LATU: next_s.rd = {8'h00, s.latu};
            REG_BANK: next_s.rd = {8'h00, s.bank};
            REG_STAT: next_s.rd = {9'h000, s.op, s.state, s.phase};
            default:  next_s.rd = '0;
         endcase
      end

      // Operand translation for standard byte and bit instructions.
      if (std_valid_in) begin
         next_s.xl.valid  = 1'b1;
         next_s.xl.dest_f = std_d_in; // [RULE_16]
         if (std_a_in) begin
            next_s.xl.addr = {s.bank[3:0], std_f_in}; // [RULE_13]
         end else if (std_f_in <= ACC_LIMIT && s.ext_en) begin
            next_s.xl.addr = fp + {4'h0, std_f_in}; // [RULE_12] [RULE_14] [RULE_15]
         end else if (std_f_in <= ACC_LIMIT) begin
            next_s.xl.addr = {4'h0, std_f_in}; // [RULE_13]
         end else begin
            next_s.xl.addr = {ACC_PAGE, std_f_in};
         end
      end

      // Instruction sequencing over the four phases of each cycle.
      case (s.state)
         ST_IDLE: begin
            if (s.phase == Q1 && instr_valid_in) begin
               next_s.op    = decode(instr_word_in, s.ext_en);
               next_s.word1 = instr_word_in;
               next_s.ret   = pc_in + PC_STEP;
               if (decode(instr_word_in, s.ext_en) != OP_NONE) begin
                  next_s.state = ST_FIRST;
               end
            end
         end
         ST_FIRST: begin
            if (s.phase == Q2 && movs) begin
               next_s.mem.re   = 1'b1; // [RULE_07]
               next_s.mem.addr = src_addr;
            end
            if (s.phase == Q3) begin
               case (s.op)
                  OP_PUSH_K: begin
                     next_s.mem.we    = 1'b1; // [RULE_08]
                     next_s.mem.addr  = fp;
                     next_s.mem.wdata = s.word1[7:0];
                     next_s.ptr[2]    = fp - 12'h001;
                  end
                  OP_SUB_P: begin
                     next_s.ptr[s.word1[7:6]] = s.ptr[s.word1[7:6]]
                                              - {6'h00, s.word1[5:0]}; // [RULE_09]
                  end
                  OP_SUB_RET: begin
                     next_s.ptr[2]  = fp - {6'h00, s.word1[5:0]}; // [RULE_10]
                     next_s.pc_load = 1'b1;
                     next_s.pc_val  = top_in;
                  end
                  OP_CALL_W: begin
                     next_s.push    = 1'b1; // [RULE_11] [RULE_18]
                     next_s.pc_load = 1'b1;
                     next_s.pc_val  = {s.latu[4:0], s.lath, s.work};
                  end
                  default: next_s.push = 1'b0;
               endcase
            end
            if (s.phase == Q4) begin
               next_s.src = is_ind(src_addr) ? 8'h00 : mem_rdata_in; // [RULE_04]
               if (movs) begin
                  next_s.state = ST_SECOND; // [RULE_07]
               end else if (s.op == OP_SUB_RET || s.op == OP_CALL_W) begin
                  next_s.state = ST_NOP; // [RULE_10] [RULE_11]
               end else begin
                  next_s.state = ST_IDLE;
               end
            end
         end
         ST_SECOND: begin
            if (s.phase == Q1) begin
               next_s.word2 = instr_word_in;
            end
            // The destination is trusted not to be the pc or return-top bytes.
            if (s.phase == Q3) begin // [RULE_03]
               next_s.mem.we    = !(s.op == OP_MOVE_X && is_ind(dst_addr)); // [RULE_05]
               next_s.mem.addr  = dst_addr;
               next_s.mem.wdata = s.src;
            end
            if (s.phase == Q4) begin
               next_s.state = ST_IDLE;
            end
         end
         ST_NOP: begin
            if (s.phase == Q4) begin
               next_s.state = ST_IDLE;
            end
         end
         default: next_s.state = ST_IDLE;
      endcase

      next_s.busy = (next_s.state != ST_IDLE);
   end

   // State register; reset clears the extension enable and all pointers.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         s <= REGS_RST; // [RULE_19]
      end else begin
         s <= next_s;
      end
   end

   // Outputs are taken straight from the state register.
   assign reg_rdata_out  = s.rd;
   assign mem_req_out    = s.mem;
   assign stack_push_out = s.push;
   assign push_value_out = s.ret;
   assign pc_load_out    = s.pc_load;
   assign pc_value_out   = s.pc_val;
   assign busy_out       = s.busy;
   assign phase_out      = s.phase;
   assign std_xlate_out  = s.xl;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   logic at_q4_first;
   assign at_q4_first = (s.state == ST_FIRST) && (s.phase == Q4);

   sequence seq_take_move_f;
      s.state == ST_IDLE && s.phase == Q1 && instr_valid_in && s.ext_en
         && instr_word_in[15:7] == {OPC_MOVS, 1'b0};
   endsequence

   sequence seq_move_body;
      (s.state == ST_FIRST) [*3] ##1 (s.state == ST_SECOND) [*3]
         ##1 (s.state == ST_SECOND && mem_req_out.we);
   endsequence

   property p_src_read;
      (s.state == ST_FIRST && s.phase == Q3 && movs)
         |-> mem_req_out.re && mem_req_out.addr == fp + {5'h00, s.word1[6:0]};
   endproperty
   a_src_read: assert property (p_src_read) else $error("Bad source read."); // [RULE_01]

   property p_move_timing;
      seq_take_move_f |=> seq_move_body;
   endproperty
   a_move_timing: assert property (p_move_timing) else $error("Move timing."); // [RULE_07]

   property p_move_f_dest;
      (s.state == ST_SECOND && s.phase == Q4 && s.op == OP_MOVE_F)
         |-> mem_req_out.we && mem_req_out.addr == s.word2[11:0]
             && mem_req_out.wdata == s.src;
   endproperty
   a_move_f_dest: assert property (p_move_f_dest) else $error("Bad dest."); // [RULE_02]

   property p_ind_zero;
      (at_q4_first && movs && is_ind(src_addr)) |=> s.src == 8'h00;
   endproperty
   a_ind_zero: assert property (p_ind_zero) else $error("Source not zero."); // [RULE_04]

   property p_move_x_nop;
      (s.state == ST_SECOND && s.phase == Q4 && s.op == OP_MOVE_X && is_ind(dst_addr))
         |-> !mem_req_out.we;
   endproperty
   a_move_x_nop: assert property (p_move_x_nop) else $error("Write to indirect."); // [RULE_05]

   property p_push_k;
      (at_q4_first && s.op == OP_PUSH_K)
         |-> mem_req_out.we && mem_req_out.addr == $past(fp)
             && fp == $past(fp) - 12'h001 && mem_req_out.wdata == s.word1[7:0];
   endproperty
   a_push_k: assert property (p_push_k) else $error("Push literal."); // [RULE_08]

   property p_sub_p;
      (at_q4_first && s.op == OP_SUB_P)
         |-> s.ptr[s.word1[7:6]] == $past(s.ptr[s.word1[7:6]]) - {6'h00, s.word1[5:0]};
   endproperty
   a_sub_p: assert property (p_sub_p) else $error("Subtract pointer."); // [RULE_09]

   property p_sub_ret;
      (at_q4_first && s.op == OP_SUB_RET)
         |-> pc_load_out && pc_value_out == $past(top_in)
             ##1 (s.state == ST_NOP) [*4] ##1 (s.state == ST_IDLE);
   endproperty
   a_sub_ret: assert property (p_sub_ret) else $error("Return form."); // [RULE_10]

   // The pushed address is the accepted pc plus one step, three edges back.
   property p_call_w;
      (at_q4_first && s.op == OP_CALL_W)
         |-> stack_push_out && push_value_out == $past(pc_in, 3) + PC_STEP && pc_load_out
             ##1 (s.state == ST_NOP) [*4];
   endproperty
   a_call_w: assert property (p_call_w) else $error("Call form."); // [RULE_11] [RULE_18]

   property p_xlate_on;
      (std_valid_in && !std_a_in && s.ext_en && std_f_in <= ACC_LIMIT)
         |=> std_xlate_out.addr == $past(fp) + {4'h0, $past(std_f_in)};
   endproperty
   a_xlate_on: assert property (p_xlate_on) else $error("Indexed operand."); // [RULE_14]

   property p_xlate_off;
      (std_valid_in && !std_a_in && !s.ext_en && std_f_in <= ACC_LIMIT)
         |=> std_xlate_out.addr == {4'h0, $past(std_f_in)};
   endproperty
   a_xlate_off: assert property (p_xlate_off) else $error("Access operand."); // [RULE_13]

   property p_gate;
      (s.state == ST_IDLE && s.phase == Q1 && instr_valid_in && !s.ext_en
         && instr_word_in != OPC_CALL_W) |=> s.state == ST_IDLE;
   endproperty
   a_gate: assert property (p_gate) else $error("Extension not gated."); // [RULE_19]

endmodule : eid_core

//--- dv/eid_core_test.sv
// Self-checking bench for the extended instruction decoder.
module eid_core_test
   import eid_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic [3:0]  reg_addr_in = 4'h0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [15:0] reg_rdata_out;
   logic        instr_valid_in = 1'b0;
   logic [15:0] instr_word_in = 16'h0000;
   logic [20:0] pc_in = 21'h000000;
   logic [20:0] top_in = 21'h000000;
   eid_mem_t    mem_req_out;
   logic [7:0]  mem_rdata_in = 8'h00;
   logic        stack_push_out;
   logic [20:0] push_value_out;
   logic        pc_load_out;
   logic [20:0] pc_value_out;
   logic        busy_out;
   logic [1:0]  phase_out;
   logic        std_valid_in = 1'b0;
   logic [7:0]  std_f_in = 8'h00;
   logic        std_a_in = 1'b0;
   logic        std_d_in = 1'b0;
   eid_xlate_t  std_xlate_out;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   int          t0 = 0;
   logic [15:0] rv;

   // The clock toggles every half period of 5 ns.
   always #5 clk_in = ~clk_in;

   eid_core #(.DATA_SPACE(4096)) i_eid_core (
      .clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .instr_valid_in(instr_valid_in),
      .instr_word_in(instr_word_in), .pc_in(pc_in), .top_in(top_in),
      .mem_req_out(mem_req_out), .mem_rdata_in(mem_rdata_in),
      .stack_push_out(stack_push_out), .push_value_out(push_value_out),
      .pc_load_out(pc_load_out), .pc_value_out(pc_value_out), .busy_out(busy_out),
      .phase_out(phase_out), .std_valid_in(std_valid_in), .std_f_in(std_f_in),
      .std_a_in(std_a_in), .std_d_in(std_d_in), .std_xlate_out(std_xlate_out));

   ////////////////////////////////////////////////////////////////////////////
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : report_and_stop

   // Cycle counter; a hung run is cut off and counted as a mismatch.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt = error_cnt + 1;
         report_and_stop();
      end
   end

   // Compares a seen value against the expected one.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge clk_in);
      reg_wr_in    <= 1'b0;
   endtask : wr

   // One-cycle register read; data is taken in the following cycle only.
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge clk_in);
      reg_rd_in   <= 1'b0;
      @(negedge clk_in);
      v = reg_rdata_out;
   endtask : rd

   // Offers a word at phase Q1 while idle; the second word follows at once.
   task automatic issue(input logic [15:0] w1, input logic [15:0] w2, input logic [20:0] pc);
      @(negedge clk_in);
      while (phase_out !== 2'h3 || busy_out !== 1'b0) @(negedge clk_in);
      @(posedge clk_in);
      instr_valid_in <= 1'b1;
      instr_word_in  <= w1;
      pc_in          <= pc;
      @(negedge clk_in);
      t0 = cyc;
      @(posedge clk_in);
      instr_valid_in <= 1'b0;
      instr_word_in  <= w2;
      @(negedge clk_in);
   endtask : issue

   // Moves to the middle of cycle n counted from the accepting cycle.
   task automatic go(input int n);
      while (cyc != t0 + n) @(negedge clk_in);
   endtask : go

   // Presents one standard operand and checks its translation.
   task automatic xl(input logic [7:0] f, input logic a, input logic d, input logic [11:0] ea);
      @(posedge clk_in);
      std_valid_in <= 1'b1;
      std_f_in     <= f;
      std_a_in     <= a;
      std_d_in     <= d;
      @(posedge clk_in);
      std_valid_in <= 1'b0;
      @(negedge clk_in);
      chk(32'(std_xlate_out), {18'h0, 1'b1, ea, d});
   endtask : xl

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and the extension held off.
   task automatic t_off();
      rd(REG_CTRL, rv);
      chk(rv, 0);
      rd(4'hf, rv);
      chk(rv, 0);
      wr(REG_BANK, 16'h0005);
      issue(16'hea08, 16'h0000, 21'h000100);
      go(3);
      chk({mem_req_out, busy_out}, 0);
      xl(8'h10, 1'b0, 1'b1, 12'h010);
      xl(8'h2c, 1'b1, 1'b0, 12'h52c);
   endtask : t_off

   // Operand translation with the extension on.
   task automatic t_xlate();
      wr(REG_CTRL, 16'h0001);
      wr(REG_FP, 16'h0a00);
      xl(8'h2c, 1'b0, 1'b0, 12'ha2c);
      xl(8'h2c, 1'b0, 1'b1, 12'ha2c);
      xl(8'h60, 1'b0, 1'b0, 12'hf60);
      xl(8'h5f, 1'b1, 1'b0, 12'h55f);
      wr(REG_FP, 16'h0fff);
      xl(8'h5f, 1'b0, 1'b0, 12'h05e);
      wr(REG_FP, 16'h0000);
      xl(8'h5f, 1'b0, 1'b1, 12'h05f);
   endtask : t_xlate

   // Push of a literal at the frame pointer.
   task automatic t_push();
      wr(REG_FP, 16'h01ec);
      issue(16'hea08, 16'h0000, 21'h000100);
      go(3);
      chk(32'(mem_req_out), {10'h0, 1'b0, 1'b1, 12'h1ec, 8'h08});
      go(4);
      chk(busy_out, 0);
      rd(REG_FP, rv);
      chk(rv, 16'h01eb);
   endtask : t_push

   // Subtraction from each of the three pointers.
   task automatic t_sub();
      logic [3:0] r;
      for (int i = 0; i < 3; i++) begin
         r = (i == 2) ? REG_FP : REG_PTR0 + 4'(i);
         wr(r, 16'h03ff);
         issue({8'he9, 2'(i), 6'h23}, 16'h0000, 21'h000100);
         go(4);
         chk(busy_out, 0);
         rd(r, rv);
         chk(rv, 16'h03dc);
      end
   endtask : t_sub

   // Subtract from the frame pointer and return.
   task automatic t_ret();
      wr(REG_FP, 16'h03ff);
      @(posedge clk_in);
      top_in <= 21'h012345;
      issue(16'he9e3, 16'h0000, 21'h000100);
      go(3);
      chk({pc_load_out, pc_value_out}, {1'b1, 21'h012345});
      go(7);
      chk({busy_out, pc_load_out}, 2'b10);
      go(8);
      chk(busy_out, 0);
      rd(REG_FP, rv);
      chk(rv, 16'h03dc);
   endtask : t_ret

   // Call through the working register.
   task automatic t_call();
      wr(REG_WORK, 16'h0006);
      wr(REG_LATH, 16'h0010);
      wr(REG_LATU, 16'h0003);
      issue(OPC_CALL_W, 16'h0000, 21'h001000);
      go(3);
      chk({stack_push_out, push_value_out}, {1'b1, 21'h001002});
      chk({pc_load_out, pc_value_out}, {1'b1, 21'h031006});
      go(7);
      chk(busy_out, 1);
      go(8);
      chk(busy_out, 0);
   endtask : t_call

   // Indexed source to an absolute destination.
   task automatic t_move_f();
      wr(REG_FP, 16'h0080);
      @(posedge clk_in);
      mem_rdata_in <= 8'h33;
      // The destination is an ordinary register, never the pc or return-top bytes.
      issue(16'heb05, 16'hf123, 21'h000100);
      go(2);
      chk({mem_req_out.re, mem_req_out.we, mem_req_out.addr}, {2'b10, 12'h085});
      go(6);
      chk(mem_req_out.we, 0);
      go(7);
      chk(32'(mem_req_out), {10'h0, 2'b01, 12'h123, 8'h33});
      chk(phase_out, Q4);
      go(8);
      chk(busy_out, 0);
   endtask : t_move_f

   // Indexed to indexed, first from an indirect source, then to an indirect target.
   task automatic t_move_x();
      wr(REG_FP, 16'h0fd0);
      @(posedge clk_in);
      mem_rdata_in <= 8'h5a;
      issue(16'heb8f, 16'hf006, 21'h000100);
      go(7);
      chk(32'(mem_req_out), {10'h0, 2'b01, 12'hfd6, 8'h00});
      wr(REG_FP, 16'h0fe0);
      issue(16'heb81, 16'hf00f, 21'h000100);
      go(2);
      chk({mem_req_out.re, mem_req_out.addr}, {1'b1, 12'hfe1});
      for (int n = 3; n < 9; n++) begin
         go(n);
         chk(mem_req_out.we, 0);
      end
   endtask : t_move_x

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset for four cycles, then every scenario in turn.
   initial begin
      repeat (4) @(posedge clk_in);
      rstn_in <= 1'b1;
      t_off();
      t_xlate();
      t_push();
      t_sub();
      t_ret();
      t_call();
      t_move_f();
      t_move_x();
      report_and_stop();
   end

endmodule : eid_core_test
